// ---- src/pinmux_pkg.sv ----
package pinmux_pkg;
   localparam int ADDR_W = 5;
   localparam logic [4:0] OFS_LATCH0   = 5'h00; // latches 0..5 at 0x00..0x05
   localparam logic [4:0] OFS_DIR0     = 5'h06; // directions 0..5 at 0x06..0x0B
   localparam logic [4:0] OFS_P0_MODE  = 5'h0C;
   localparam logic [4:0] OFS_P2_MODE  = 5'h0D;
   localparam logic [4:0] OFS_P3_MODE  = 5'h0E;
   localparam logic [4:0] OFS_MEM_MAP  = 5'h0F;
   localparam logic [4:0] OFS_RTO_BUF  = 5'h10;
   localparam logic [4:0] OFS_EXT_ALO  = 5'h11;
   localparam logic [4:0] OFS_EXT_AHI  = 5'h12;
   localparam logic [4:0] OFS_EXT_DATA = 5'h13;
   localparam logic [4:0] OFS_EXT_CMD  = 5'h14;
   localparam logic [4:0] OFS_STATUS   = 5'h15;
   localparam int NUM_PORTS = 6;
   localparam int BUS_PORT  = 4;
   localparam int HI_PORT   = 5;
   // mem map fields
   localparam int MM_SIZE_LSB = 0;
   localparam int MM_BUS_EN   = 2;
   localparam int MM_WAIT_LSB = 4;
   localparam logic [1:0] SIZE_256 = 2'h0;
   localparam logic [1:0] SIZE_4K  = 2'h1;
   localparam logic [1:0] SIZE_16K = 2'h2;
   localparam logic [1:0] SIZE_56K = 2'h3;
   localparam logic [7:0] HI_MASK_256 = 8'h00;
   localparam logic [7:0] HI_MASK_4K  = 8'h0F;
   localparam logic [7:0] HI_MASK_16K = 8'h3F;
   localparam logic [7:0] HI_MASK_56K = 8'hFF;
   localparam int CMD_READ  = 0;
   localparam int CMD_WRITE = 1;
   localparam int P2_SYNC   = 0;
   localparam int P3_TMR6   = 2;
   localparam int P3_TMR7   = 3;
   localparam logic [7:0] REG_RESET = 8'h00;
   // machine state rate
   localparam int OSC_MAX_MHZ     = 12;
   localparam int STATE_MAX_MHZ   = OSC_MAX_MHZ / 2;
   localparam int CLKS_PER_STATE  = OSC_MAX_MHZ / STATE_MAX_MHZ;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'h0,
      BUS_ADDR = 3'h1,
      BUS_GAP  = 3'h3,
      BUS_STRB = 3'h2,
      BUS_HOLD = 3'h6
   } bus_state_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pad_drive_t;

   typedef struct packed {
      logic       serial_txd;
      logic       serial_sck;
      logic       serial_rxclk_out;
      logic       serial_rxclk_oe;
      logic [1:0] pulse_width_out;
      logic [1:0] timer_flop_out;
   } periph_drive_t;

   typedef struct packed {
      logic       nmi_in;
      logic [2:0] maskable_irq_in;
      logic       serial_rxd;
      logic       serial_cts;
      logic       serial_rxclk_in;
      logic [1:0] updown_count_in;
      logic [1:0] updown_control_in;
      logic [1:0] updown_clear_in;
   } periph_sense_t;
endpackage : pinmux_pkg

// ---- src/port_pin_function_and_external_bus.sv ----
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module port_pin_function_and_external_bus (
   input  wire logic                          core_clk_i,
   input  wire logic                          nrst_i,
   input  wire logic [pinmux_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]                    reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [7:0]                    reg_rdata_o,
   input  wire logic                          external_fetch_select_n_i,
   output logic                               ext_fetch_o,
   input  wire logic [5:0][7:0]               pad_in_i,
   output pinmux_pkg::pad_drive_t [5:0]       pad_o,
   output logic                               ale_o,
   output logic                               rd_n_o,
   output logic                               wr_n_o,
   input  wire logic [1:0]                    rto_trigger_i,
   input  pinmux_pkg::periph_drive_t          periph_i,
   output pinmux_pkg::periph_sense_t          periph_o
);
   import pinmux_pkg::*;

   logic [5:0][7:0] port_latch;
   logic [5:0][7:0] port_dir;
   logic [7:0]      p0_mode;
   logic [7:0]      p2_mode;
   logic [7:0]      p3_mode;
   logic [7:0]      mem_map;
   logic [7:0]      rto_buf;
   logic [7:0]      rto_latch;
   logic [7:0]      ext_alo;
   logic [7:0]      ext_ahi;
   logic [7:0]      ext_data;
   logic            req_pend;
   logic            req_write;
   logic            state_phase;
   logic [1:0]      wait_cnt;
   bus_state_t      bus_state;
   bus_state_t      next_bus_state;

   // per-pin function ownership, function drive value and enable
   logic [5:0][7:0] func_sel;
   logic [5:0][7:0] func_out;
   logic [5:0][7:0] func_oe;

   wire ea_low      = ~external_fetch_select_n_i;
   wire bus_mode    = mem_map[MM_BUS_EN] | ea_low;
   wire [1:0] size  = mem_map[MM_SIZE_LSB +: 2];
   wire [1:0] waits = mem_map[MM_WAIT_LSB +: 2];
   wire state_tick  = state_phase;
   wire busy        = req_pend | (bus_state != BUS_IDLE);
   wire strb_last   = (bus_state == BUS_STRB) && (wait_cnt == waits);

   wire wr_hit      = reg_wr_i;
   wire hit_cmd     = wr_hit && (reg_addr_i == OFS_EXT_CMD);
   wire start_rd    = hit_cmd && reg_wdata_i[CMD_READ];
   wire start_wr    = hit_cmd && reg_wdata_i[CMD_WRITE] && !reg_wdata_i[CMD_READ];
   // commands while busy or with no bus configured are dropped
   wire start_ok    = (start_rd | start_wr) && !busy && bus_mode;

   assign ext_fetch_o = ea_low;

   logic [7:0] hi_mask;
   always_comb begin
      case (size)
         SIZE_256: hi_mask = HI_MASK_256;
         SIZE_4K:  hi_mask = HI_MASK_4K;
         SIZE_16K: hi_mask = HI_MASK_16K;
         SIZE_56K: hi_mask = HI_MASK_56K;
         default:  hi_mask = HI_MASK_256;
      endcase
      if (ea_low) begin
         hi_mask = HI_MASK_56K;
      end
   end

   // bus sequencer: address, gap, strobe plus waits, hold
   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         BUS_IDLE: if (req_pend) begin
            next_bus_state = BUS_ADDR;
         end
         BUS_ADDR: next_bus_state = BUS_GAP;
         BUS_GAP:  next_bus_state = BUS_STRB;
         BUS_STRB: if (wait_cnt == waits) begin
            next_bus_state = BUS_HOLD;
         end
         BUS_HOLD: next_bus_state = BUS_IDLE;
         default:  next_bus_state = BUS_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         state_phase <= 1'b0;
         bus_state   <= BUS_IDLE;
         wait_cnt    <= 2'h0;
      end else begin
         state_phase <= ~state_phase;
         if (state_tick) begin
            bus_state <= next_bus_state;
            wait_cnt  <= (bus_state == BUS_STRB && !strb_last) ? wait_cnt + 2'h1 : 2'h0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         req_pend  <= 1'b0;
         req_write <= 1'b0;
      end else if (start_ok) begin
         req_pend  <= 1'b1;
         req_write <= start_wr;
      end else if (state_tick && bus_state == BUS_IDLE) begin
         req_pend  <= 1'b0;
      end
   end

   // latch pulse comes straight from the state register, strobes from it and req_write
   assign ale_o  = (bus_state == BUS_ADDR);
   assign rd_n_o = ~((bus_state == BUS_STRB) && !req_write);
   assign wr_n_o = ~((bus_state == BUS_STRB) && req_write);

   // software registers
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         port_latch <= '0;
         port_dir   <= '0;
         p0_mode    <= REG_RESET;
         p2_mode    <= REG_RESET;
         p3_mode    <= REG_RESET;
         mem_map    <= REG_RESET;
         rto_buf    <= REG_RESET;
         rto_latch  <= REG_RESET;
         ext_alo    <= REG_RESET;
         ext_ahi    <= REG_RESET;
         ext_data   <= REG_RESET;
      end else begin
         if (wr_hit) begin
            case (reg_addr_i)
               OFS_P0_MODE:  p0_mode  <= reg_wdata_i;
               OFS_P2_MODE:  p2_mode  <= reg_wdata_i;
               OFS_P3_MODE:  p3_mode  <= reg_wdata_i;
               OFS_MEM_MAP:  mem_map  <= reg_wdata_i;
               OFS_RTO_BUF:  rto_buf  <= reg_wdata_i;
               OFS_EXT_ALO:  if (!busy) ext_alo <= reg_wdata_i;
               OFS_EXT_AHI:  if (!busy) ext_ahi <= reg_wdata_i;
               OFS_EXT_DATA: if (!busy) ext_data <= reg_wdata_i;
               default: begin
                  if (reg_addr_i < OFS_DIR0) begin
                     port_latch[reg_addr_i[2:0]] <= reg_wdata_i;
                  end else if (reg_addr_i < OFS_P0_MODE) begin
                     port_dir[3'(reg_addr_i - OFS_DIR0)] <= reg_wdata_i;
                  end
               end
            endcase
         end
         // read data sampled on the last strobe state, while the part drives
         if (state_tick && strb_last && !req_write) begin
            ext_data <= pad_in_i[BUS_PORT];
         end
         // real-time nibble transfer on its timer trigger
         if (rto_trigger_i[0]) begin
            rto_latch[3:0] <= rto_buf[3:0];
         end
         if (rto_trigger_i[1]) begin
            rto_latch[7:4] <= rto_buf[7:4];
         end
      end
   end

   // port 0: nibble real-time outputs
   assign func_sel[0] = {{4{p0_mode[1]}}, {4{p0_mode[0]}}};
   assign func_out[0] = rto_latch;
   assign func_oe[0]  = 8'hFF;

   // port 1: general purpose only
   assign func_sel[1] = 8'h00;
   assign func_out[1] = 8'h00;
   assign func_oe[1]  = 8'h00;

   // port 2
   wire p2_sync = p2_mode[P2_SYNC];
   assign func_sel[2] = {p2_mode[7:4], 4'hF};
   assign func_out[2] = {periph_i.serial_rxclk_out, periph_i.serial_sck, 1'b0,
                         periph_i.serial_txd, 4'h0};
   assign func_oe[2]  = {p2_sync & periph_i.serial_rxclk_oe, 1'b1, 1'b0, 1'b1, 4'h0};

   // port 3: timer output wins over clear input when both are chosen
   wire [1:0] p3_tmr = {p3_mode[P3_TMR7], p3_mode[P3_TMR6]};
   wire [1:0] p3_clr = p3_mode[7:6] & ~p3_tmr;
   assign func_sel[3] = {p3_tmr | p3_mode[7:6], p3_mode[5:4], 4'hF};
   assign func_out[3] = {periph_i.timer_flop_out, periph_i.pulse_width_out, 4'h0};
   assign func_oe[3]  = {p3_tmr, 2'b11, 4'h0};

   // port 4: whole-port direction, bus owns it in bus mode
   wire bus_drv = (bus_state == BUS_ADDR) ||
                  ((bus_state == BUS_STRB || bus_state == BUS_HOLD) && req_write);
   assign func_sel[4] = {8{bus_mode}};
   assign func_out[4] = (bus_state == BUS_ADDR) ? ext_alo : ext_data;
   assign func_oe[4]  = {8{bus_drv}};

   // port 5: upper address lines, leftovers stay plain I/O
   assign func_sel[5] = bus_mode ? hi_mask : 8'h00;
   assign func_out[5] = ext_ahi;
   assign func_oe[5]  = 8'hFF;

   // final pad drive, one cell per pin
   genvar gp;
   genvar gb;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         for (gb = 0; gb < 8; gb++) begin : g_bit
            wire dir_bit = (gp == BUS_PORT) ? port_dir[gp][0] : port_dir[gp][gb];
            assign pad_o[gp].out[gb] = func_sel[gp][gb] ? func_out[gp][gb]
                                                         : port_latch[gp][gb];
            assign pad_o[gp].oe[gb]  = func_sel[gp][gb] ? func_oe[gp][gb]
                                                         : dir_bit;
         end
      end
   endgenerate

   // inputs to peripherals, fixed pins always routed
   assign periph_o.nmi_in            = pad_in_i[2][0];
   assign periph_o.maskable_irq_in   = pad_in_i[2][3:1];
   assign periph_o.serial_rxd        = p2_mode[5] & pad_in_i[2][5];
   assign periph_o.serial_cts        = p2_mode[7] & ~p2_sync & pad_in_i[2][7];
   assign periph_o.serial_rxclk_in   = p2_mode[7] & p2_sync & pad_in_i[2][7];
   assign periph_o.updown_count_in   = {pad_in_i[3][2], pad_in_i[3][0]};
   assign periph_o.updown_control_in = {pad_in_i[3][3], pad_in_i[3][1]};
   assign periph_o.updown_clear_in   = p3_clr & pad_in_i[3][7:6];

   // register read: input bits show the pin, output bits the latch
   logic [7:0] rd_val;
   always_comb begin
      rd_val = 8'h00;
      case (reg_addr_i)
         OFS_P0_MODE:  rd_val = p0_mode;
         OFS_P2_MODE:  rd_val = p2_mode;
         OFS_P3_MODE:  rd_val = p3_mode;
         OFS_MEM_MAP:  rd_val = mem_map;
         OFS_RTO_BUF:  rd_val = rto_buf;
         OFS_EXT_ALO:  rd_val = ext_alo;
         OFS_EXT_AHI:  rd_val = ext_ahi;
         OFS_EXT_DATA: rd_val = ext_data;
         OFS_EXT_CMD:  rd_val = {7'h00, busy};
         OFS_STATUS:   rd_val = {5'h00, bus_mode, ea_low, busy};
         default: begin
            if (reg_addr_i < OFS_DIR0) begin
               rd_val = (pad_o[reg_addr_i[2:0]].oe & port_latch[reg_addr_i[2:0]]) |
                        (~pad_o[reg_addr_i[2:0]].oe & pad_in_i[reg_addr_i[2:0]]);
            end else if (reg_addr_i < OFS_P0_MODE) begin
               rd_val = port_dir[3'(reg_addr_i - OFS_DIR0)];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_val : 8'h00;
      end
   end
endmodule : port_pin_function_and_external_bus

// ---- bench/pinmux_checker.sv ----
`timescale 1ns/1ps
module pinmux_checker (
   input  wire logic                    core_clk_i,
   input  wire logic                    nrst_i,
   input  wire logic [7:0]              reg_rdata_o,
   input  wire logic                    external_fetch_select_n_i,
   input  wire logic                    ext_fetch_o,
   input  wire logic [5:0][7:0]         pad_in_i,
   input  pinmux_pkg::pad_drive_t [5:0] pad_o,
   input  wire logic                    ale_o,
   input  wire logic                    rd_n_o,
   input  wire logic                    wr_n_o,
   input  pinmux_pkg::periph_sense_t    periph_o
);
   import pinmux_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_gap;
      rd_n_o && wr_n_o && pad_o[4].oe == 8'h00;
   endsequence
   sequence s_strb;
      !rd_n_o || !wr_n_o;
   endsequence
   property p_ale;
      $rose(ale_o) |-> pad_o[4].oe == 8'hFF ##1 ale_o ##1 !ale_o;
   endproperty
   property p_gap;
      $fell(ale_o) |-> s_gap [*2] ##1 s_strb;
   endproperty
   property p_rd_float;
      !rd_n_o |-> pad_o[4].oe == 8'h00 && !ale_o;
   endproperty
   property p_wr_drive;
      !wr_n_o |-> pad_o[4].oe == 8'hFF && rd_n_o;
   endproperty
   property p_fetch;
      ext_fetch_o == !external_fetch_select_n_i;
   endproperty
   property p_ea_hi;
      !external_fetch_select_n_i [*2] |-> pad_o[5].oe == 8'hFF;
   endproperty
   property p_fixed_in;
      pad_o[2].oe[3:0] == 4'h0 && pad_o[3].oe[3:0] == 4'h0;
   endproperty
   property p_irq;
      periph_o.nmi_in == pad_in_i[2][0] && periph_o.maskable_irq_in == pad_in_i[2][3:1];
   endproperty
   property p_cnt;
      periph_o.updown_count_in == {pad_in_i[3][2], pad_in_i[3][0]}
         && periph_o.updown_control_in == {pad_in_i[3][3], pad_in_i[3][1]};
   endproperty
   property p_reset;
      $rose(nrst_i) |-> !ale_o && rd_n_o && wr_n_o && reg_rdata_o == 8'h00;
   endproperty
   a_ale: assert property (p_ale) else $error("latch strobe pulse wrong");
   a_gap: assert property (p_gap) else $error("address gap wrong");
   a_rd_float: assert property (p_rd_float) else $error("bus driven in read");
   a_wr_drive: assert property (p_wr_drive) else $error("bus idle in write");
   a_fetch: assert property (p_fetch) else $error("fetch select wrong");
   a_ea_hi: assert property (p_ea_hi) else $error("high port not full");
   a_fixed_in: assert property (p_fixed_in) else $error("input pin driven");
   a_irq: assert property (p_irq) else $error("irq routing wrong");
   a_cnt: assert property (p_cnt) else $error("counter routing wrong");
   a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : pinmux_checker

bind port_pin_function_and_external_bus pinmux_checker pinmux_checker_i (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_rdata_o(reg_rdata_o),
   .external_fetch_select_n_i(external_fetch_select_n_i), .ext_fetch_o(ext_fetch_o),
   .pad_in_i(pad_in_i), .pad_o(pad_o), .ale_o(ale_o), .rd_n_o(rd_n_o),
   .wr_n_o(wr_n_o), .periph_o(periph_o));

// ---- bench/ext_mem_model.sv ----
`timescale 1ns/1ps
module ext_mem_model (
   input  wire logic              clk_i,
   input  pinmux_pkg::pad_drive_t ad_i,
   input  pinmux_pkg::pad_drive_t hi_i,
   input  wire logic              ale_i,
   input  wire logic              rd_n_i,
   input  wire logic              wr_n_i,
   input  wire logic [3:0]        lag_i,
   output logic      [7:0]        data_o
);
   import pinmux_pkg::*;
   logic [7:0]  mem [65536];
   logic [15:0] addr  = 16'h0000;
   logic [7:0]  last  = 8'h5A;
   logic [3:0]  n_low = 4'h0;
   wire         ready = !rd_n_i && n_low >= lag_i;
   // no keeper on the bus: show the inverse so a stale sample is caught
   assign data_o = ready ? mem[addr] : ~last;
   always @(posedge clk_i) begin
      n_low <= rd_n_i ? 4'h0 : n_low + 4'h1;
      if (ale_i) addr <= {hi_i.out & hi_i.oe, ad_i.out};
      if (!wr_n_i) mem[addr] <= ad_i.out;
      if (ready) last <= mem[addr];
   end
endmodule : ext_mem_model

// ---- bench/port_pin_function_and_external_bus_tb_top.sv ----
`timescale 1ns/1ps
module port_pin_function_and_external_bus_tb_top;
   import pinmux_pkg::*;
   logic             clk = 1'b0;
   logic             nrst = 1'b0;
   logic [4:0]       addr = 5'h00;
   logic [7:0]       wdata = 8'h00;
   logic             wr_s = 1'b0;
   logic             rd_s = 1'b0;
   logic [7:0]       rdata;
   logic             ea_n = 1'b1;
   logic             fetch;
   logic [5:0][7:0]  pins = '0;
   logic [5:0][7:0]  pad_in;
   pad_drive_t [5:0] pad;
   logic             ale, rd_n, wr_n;
   logic [1:0]       rto = 2'h0;
   periph_drive_t    per_i = '0;
   periph_sense_t    per_o;
   logic [7:0]       mem_bus;
   logic [3:0]       lag = 4'h0;
   logic [7:0]       expq [$];
   logic             rd_d = 1'b0;
   int               failures = 0;
   int               n_tests = 0;
   always #4 clk = ~clk;
   always_comb begin
      for (int p = 0; p < 6; p++) begin
         pad_in[p] = (pad[p].oe & pad[p].out) | (~pad[p].oe & (p == 4 ? mem_bus : pins[p]));
      end
   end
   port_pin_function_and_external_bus port_pin_function_and_external_bus_i (
      .core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
      .external_fetch_select_n_i(ea_n), .ext_fetch_o(fetch), .pad_in_i(pad_in),
      .pad_o(pad), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n), .rto_trigger_i(rto),
      .periph_i(per_i), .periph_o(per_o));
   ext_mem_model ext_mem_model_i (.clk_i(clk), .ad_i(pad[4]), .hi_i(pad[5]), .ale_i(ale),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .lag_i(lag), .data_o(mem_bus));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   task automatic wr(input int a, input logic [7:0] d);
      @(posedge clk);
      addr <= 5'(a);
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd(input int a, input logic [7:0] e);
      expq.push_back(e);
      @(posedge clk);
      addr <= 5'(a);
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
   endtask : rd
   // one bus cycle; strobe length counted on settled values
   task automatic ext(input logic [7:0] cmd, input int w);
      int n;
      wr(OFS_EXT_CMD, cmd);
      n = 0;
      while (rd_n && wr_n && n < 40) begin @(negedge clk); n++; end
      n = 0;
      while (!(rd_n && wr_n) && n < 20) begin @(negedge clk); n++; end
      chk("strobe_len", 16'(2 * (1 + w)), 16'(n));
      repeat (4) @(posedge clk);
   endtask : ext
   always @(posedge clk) begin
      rd_d <= rd_s;
      if (rd_d) chk("rdata", expq.pop_front(), rdata);
   end
   initial begin
      #100000;
      failures++;
      print_verdict();
   end
   initial begin
      logic [7:0] d, m, a, h, mk;
      int plist[3];
      plist = '{0, 1, 5};
      void'($urandom(32'hC853));
      pins = 48'({$urandom, $urandom});
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int r = 6; r < 22; r++) rd(r, 8'h00);
      rd(31, 8'h00);
      $display("test reset_values done");
      foreach (plist[i]) begin
         d = 8'($urandom);
         m = 8'($urandom);
         wr(OFS_LATCH0 + plist[i], d);
         wr(OFS_DIR0 + plist[i], m);
         @(negedge clk);
         chk("dir", m, pad[plist[i]].oe);
         chk("latch", d & m, pad[plist[i]].out & m);
         rd(OFS_LATCH0 + plist[i], (d & m) | (pins[plist[i]] & ~m));
      end
      // port 4 turns as a whole on one direction bit
      wr(OFS_LATCH0 + 4, d);
      wr(OFS_DIR0 + 4, 8'h01);
      @(negedge clk);
      chk("p4_oe", 8'hFF, pad[4].oe);
      chk("p4_out", d, pad[4].out);
      $display("test port_bits done");
      d = 8'($urandom);
      wr(OFS_LATCH0, 8'h00);
      wr(OFS_DIR0, 8'hFF);
      wr(OFS_RTO_BUF, d);
      wr(OFS_P0_MODE, 8'h03);
      rto <= 2'h1;
      @(posedge clk);
      rto <= 2'h0;
      @(negedge clk);
      chk("rto_lo", {4'h0, d[3:0]}, pad[0].out);
      @(posedge clk);
      rto <= 2'h2;
      @(posedge clk);
      rto <= 2'h0;
      @(negedge clk);
      chk("rto_hi", d, pad[0].out);
      $display("test real_time done");
      wr(OFS_DIR0 + 2, 8'h00);
      per_i <= periph_drive_t'(8'($urandom));
      wr(OFS_P2_MODE, 8'hF0);
      @(negedge clk);
      chk("p2_oe", 2'b11, {pad[2].oe[6], pad[2].oe[4]});
      chk("p2_out", {per_i.serial_sck, per_i.serial_txd}, {pad[2].out[6], pad[2].out[4]});
      chk("rxd", pins[2][5], per_o.serial_rxd);
      chk("cts", pins[2][7], per_o.serial_cts);
      wr(OFS_P2_MODE, 8'h81);
      @(negedge clk);
      chk("rxclk_oe", per_i.serial_rxclk_oe, pad[2].oe[7]);
      chk("rxclk_in", pad_in[2][7], per_o.serial_rxclk_in);
      wr(OFS_P3_MODE, 8'h3C);
      @(negedge clk);
      chk("p3_oe", 4'hF, pad[3].oe[7:4]);
      chk("p3_out", {per_i.timer_flop_out, per_i.pulse_width_out}, pad[3].out[7:4]);
      wr(OFS_P3_MODE, 8'hC0);
      @(negedge clk);
      chk("clr", pins[3][7:6], per_o.updown_clear_in);
      $display("test pin_functions done");
      wr(OFS_DIR0 + 5, 8'h00);
      for (int k = 0; k < 4; k++) begin
         a = 8'($urandom);
         h = 8'($urandom);
         d = 8'($urandom);
         mk = k == 0 ? 8'h00 : k == 1 ? 8'h0F : k == 2 ? 8'h3F : 8'hFF;
         wr(OFS_MEM_MAP, {2'b00, 2'(k), 2'b01, 2'(k)});
         lag <= k[0] ? 4'(2 * k + 1) : 4'h0;
         @(negedge clk);
         chk("hi_oe", mk, pad[5].oe);
         wr(OFS_EXT_ALO, a);
         wr(OFS_EXT_AHI, h);
         wr(OFS_EXT_DATA, d);
         ext(8'h02, k);
         chk("mem", d, ext_mem_model_i.mem[{h & mk, a}]);
         wr(OFS_EXT_DATA, ~d);
         ext(8'h01, k);
         rd(OFS_EXT_DATA, d);
      end
      $display("test ext_bus done");
      wr(OFS_MEM_MAP, 8'h00);
      ea_n <= 1'b0;
      a = 8'($urandom);
      h = 8'($urandom);
      d = 8'($urandom);
      @(negedge clk);
      chk("ea_hi_oe", 8'hFF, pad[5].oe);
      chk("fetch", 1'b1, fetch);
      wr(OFS_EXT_ALO, a);
      wr(OFS_EXT_AHI, h);
      wr(OFS_EXT_DATA, d);
      ext(8'h02, 0);
      chk("ea_mem", d, ext_mem_model_i.mem[{h, a}]);
      $display("test ext_access done");
      // mid-run reset: P3 mode, bus data and direction 0 must read back clear
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(OFS_P3_MODE, 8'h00);
      rd(OFS_EXT_DATA, 8'h00);
      rd(OFS_DIR0, 8'h00);
      rd(OFS_STATUS, 8'h06);
      $display("test mid_reset done");
      repeat (3) @(posedge clk);
      print_verdict();
   end
endmodule : port_pin_function_and_external_bus_tb_top
